// ==== include/dmx_pkg.sv ====
package dmx_pkg;
    // Instruction word layout
    localparam int INSN_W = 16;
    localparam logic [2:0] PF_OPC = 3'h2;
    localparam int PF_OPC_LSB = 13;
    localparam int PF_SRC_LSB = 8;
    localparam int PF_SRC_W = 5;
    localparam logic [7:0] WF_OPC = 8'h01;
    localparam int WF_OPC_LSB = 8;
    localparam int DST_LSB = 0;
    localparam int DST_W = 8;

    // Data space
    localparam logic [7:0] SRC_TOP = 8'h1F;
    localparam logic [7:0] DST_TOP = 8'hFF;
    localparam logic [7:0] IND0_ADDR = 8'h00;
    localparam logic [7:0] IND1_ADDR = 8'h08;
    localparam logic [7:0] WORK_ADDR = 8'h0A;

    // Reset values
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic ZERO_RST = 1'b0;

    // Quarter-cycle sequencer; Q1 is the decode slot while idle
    typedef enum logic [1:0] {
        DMX_Q1,
        DMX_Q2,
        DMX_Q3,
        DMX_Q4
    } dmx_phase_t;
endpackage

// ==== src/dmx_decode.sv ====
`timescale 1ns/1ns
module dmx_decode (
    // Instruction and pointers
    input wire logic [15:0] insn,
    input wire logic [7:0] ptr0,
    input wire logic [7:0] ptr1,
    // Decoded operation
    output logic is_pf,
    output logic is_wf,
    output logic [7:0] src_addr,
    output logic [7:0] dst_addr,
    output logic src_is_w,
    output logic dst_is_w
);
    // Indirect slots are replaced by the matching pointer value
    function automatic logic [7:0] resolve(input logic [7:0] a, input logic [7:0] p0,
                                           input logic [7:0] p1);
        logic [7:0] r;
        r = a;
        if (a == dmx_pkg::IND0_ADDR) begin
            r = p0;
        end else if (a == dmx_pkg::IND1_ADDR) begin
            r = p1;
        end
        return r;
    endfunction

    wire [2:0] opc_hi = insn[dmx_pkg::PF_OPC_LSB +: 3];
    wire [7:0] opc_wf = insn[dmx_pkg::WF_OPC_LSB +: 8];
    wire [7:0] src_raw = {3'h0, insn[dmx_pkg::PF_SRC_LSB +: dmx_pkg::PF_SRC_W]};
    wire [7:0] dst_raw = insn[dmx_pkg::DST_LSB +: dmx_pkg::DST_W];

    assign is_pf = (opc_hi == dmx_pkg::PF_OPC);
    assign is_wf = (opc_wf == dmx_pkg::WF_OPC);
    assign src_addr = resolve(src_raw, ptr0, ptr1);
    assign dst_addr = resolve(dst_raw, ptr0, ptr1);
    assign src_is_w = (src_addr == dmx_pkg::WORK_ADDR);
    assign dst_is_w = (dst_addr == dmx_pkg::WORK_ADDR);
endmodule

// ==== src/dmx_move_exec.sv ====
`timescale 1ns/1ns
module dmx_move_exec (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Instruction
    input wire logic insn_valid,
    output logic insn_ready,
    input wire logic [15:0] insn,
    // Indirect pointers from the datapath
    input wire logic [7:0] ptr0,
    input wire logic [7:0] ptr1,
    // Register file read port
    output logic rf_rd_en,
    output logic [7:0] rf_rd_addr,
    input wire logic [7:0] rf_rd_data,
    // Register file write port
    output logic rf_wr_en,
    output logic [7:0] rf_wr_addr,
    output logic [7:0] rf_wr_data,
    // Working register load from the rest of the core
    input wire logic work_ld,
    input wire logic [7:0] work_ld_data,
    output logic [7:0] working_register,
    // Status and completion
    output logic zero_flag,
    output logic zero_we,
    output logic done,
    output logic unsupported
);
    dmx_pkg::dmx_phase_t phase_q, phase_d;
    logic pf_q;
    logic wf_q;
    logic src_w_q;
    logic dst_w_q;
    logic [7:0] rd_addr_q;
    logic [7:0] dst_q;
    logic [7:0] data_q;
    logic [7:0] work_q;
    logic zero_q;
    logic zero_calc_q;
    logic unsup_q;

    wire dec_pf;
    wire dec_wf;
    wire [7:0] dec_src;
    wire [7:0] dec_dst;
    wire dec_src_w;
    wire dec_dst_w;

    dmx_decode u_decode (
        .insn(insn),
        .ptr0(ptr0),
        .ptr1(ptr1),
        .is_pf(dec_pf),
        .is_wf(dec_wf),
        .src_addr(dec_src),
        .dst_addr(dec_dst),
        .src_is_w(dec_src_w),
        .dst_is_w(dec_dst_w)
    );

    wire accept = clk_en && insn_valid && (phase_q == dmx_pkg::DMX_Q1);
    wire in_q2 = (phase_q == dmx_pkg::DMX_Q2);
    wire in_q4 = (phase_q == dmx_pkg::DMX_Q4);
    wire active = pf_q || wf_q;
    // source taken from the working register for WF and for PF moves that name it, else from the read port
    wire [7:0] src_val = (pf_q && !src_w_q) ? rf_rd_data : work_q;

    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            dmx_pkg::DMX_Q1: begin
                if (insn_valid) begin
                    phase_d = dmx_pkg::DMX_Q2;
                end
            end
            dmx_pkg::DMX_Q2: phase_d = dmx_pkg::DMX_Q3;
            dmx_pkg::DMX_Q3: phase_d = dmx_pkg::DMX_Q4;
            dmx_pkg::DMX_Q4: phase_d = dmx_pkg::DMX_Q1;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= dmx_pkg::DMX_Q1;
        end else if (clk_en) begin
            phase_q <= phase_d;
        end
    end

    // Q1 decode: operands are resolved here, ahead of any access
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pf_q <= 1'b0;
            wf_q <= 1'b0;
            src_w_q <= 1'b0;
            dst_w_q <= 1'b0;
            rd_addr_q <= 8'h00;
            dst_q <= 8'h00;
            unsup_q <= 1'b0;
        end else if (accept) begin
            pf_q <= dec_pf;
            wf_q <= dec_wf && !dec_pf;
            unsup_q <= !dec_pf && !dec_wf;
            src_w_q <= dec_src_w;
            dst_w_q <= dec_dst_w;
            rd_addr_q <= dec_pf ? dec_src : dec_dst;
            dst_q <= dec_dst;
        end
    end

    // Q2 read, Q3 execute
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= 8'h00;
            zero_calc_q <= 1'b0;
        end else if (clk_en) begin
            if (in_q2) begin
                data_q <= src_val;
            end
            if (phase_q == dmx_pkg::DMX_Q3) begin
                zero_calc_q <= (data_q == 8'h00);
            end
        end
    end

    // Q4 write; the move into the working register wins over a core load
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            work_q <= dmx_pkg::WORK_RST;
        end else if (clk_en) begin
            if (in_q4 && pf_q && dst_w_q) begin
                work_q <= data_q;
            end else if (work_ld) begin
                work_q <= work_ld_data;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_q <= dmx_pkg::ZERO_RST;
        end else if (clk_en && in_q4 && pf_q) begin
            zero_q <= zero_calc_q;
        end
    end

    assign insn_ready = (phase_q == dmx_pkg::DMX_Q1);
    assign rf_rd_en = clk_en && in_q2 && active && !(pf_q && src_w_q);
    assign rf_rd_addr = rd_addr_q;
    assign rf_wr_en = clk_en && in_q4 && active && !dst_w_q;
    assign rf_wr_addr = dst_q;
    assign rf_wr_data = data_q;
    assign working_register = work_q;
    assign zero_flag = zero_q;
    assign zero_we = clk_en && in_q4 && pf_q;
    assign done = clk_en && in_q4;
    assign unsupported = clk_en && in_q4 && unsup_q;

    default clocking dmx_cb @(posedge core_clk iff clk_en);
    endclocking
    default disable iff (!rst_n);

    sequence pf_take_s;
        insn_ready && insn_valid && (insn[15:13] == dmx_pkg::PF_OPC);
    endsequence

    sequence quarter_walk_s;
        in_q2 ##1 (phase_q == dmx_pkg::DMX_Q3) ##1 done;
    endsequence

    pf_cycle_a: assert property (pf_take_s |-> ##1 quarter_walk_s ##1
                                 zero_flag == ($past(data_q) == 8'h00))
        else $error("move did not finish in four quarters with zero updated");

    pf_dest_a: assert property ((pf_take_s and (insn[7:0] != dmx_pkg::IND0_ADDR
                                 && insn[7:0] != dmx_pkg::IND1_ADDR
                                 && insn[7:0] != dmx_pkg::WORK_ADDR))
                                |-> ##3 rf_wr_en && rf_wr_addr == $past(insn[7:0], 3))
        else $error("direct destination not written");

    src_window_a: assert property ((pf_take_s and
                                    (insn[12:8] != 5'h00 && insn[12:8] != 5'h08))
                                   |-> ##1 rf_rd_addr <= dmx_pkg::SRC_TOP)
        else $error("source address left the low window");

    w_dest_a: assert property (done && pf_q && dst_w_q |=>
                               working_register == $past(data_q) && !$past(rf_wr_en))
        else $error("working register destination not loaded");

    w_source_a: assert property (in_q2 && pf_q && src_w_q |->
                                 !rf_rd_en ##1 data_q == $past(work_q))
        else $error("working register source not routed");

    ind_src_a: assert property ((pf_take_s and (insn[12:8] == 5'h08)) |->
                                ##1 rf_rd_addr == $past(ptr1))
        else $error("indirect source not resolved");

    ind_dst_a: assert property ((pf_take_s and
                                 (insn[7:0] == dmx_pkg::IND0_ADDR && ptr0 != dmx_pkg::WORK_ADDR))
                                |-> ##3 rf_wr_en && rf_wr_addr == $past(ptr0, 3))
        else $error("indirect destination not resolved");

    wf_flags_a: assert property ((insn_ready && insn_valid
                                  && insn[15:8] == dmx_pkg::WF_OPC)
                                 |-> ##1 rf_rd_en ##2 (done && !zero_we) ##1 $stable(zero_flag))
        else $error("working register store touched the flags or missed a quarter");

    wf_self_a: assert property (done && wf_q && dst_w_q |-> !rf_wr_en)
        else $error("working register store wrote the register file");
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic insn_valid = 1'b0;
    logic [15:0] insn = 16'h0000;
    logic [7:0] ptr0 = 8'h00;
    logic [7:0] ptr1 = 8'h00;
    logic clk_en = 1'b1;
    logic work_ld = 1'b0;
    logic [7:0] work_ld_data = 8'h00;
    logic insn_ready, rf_rd_en, rf_wr_en, zero_flag, zero_we, done, unsupported;
    logic [7:0] rf_rd_addr, rf_rd_data, rf_wr_addr, rf_wr_data, working_register;
    logic [7:0] mem [256];
    logic s_wen, s_zwe, s_rd, s_uns;
    logic [7:0] s_waddr, s_wdata, s_raddr;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    int hold = 0;

    always #20 core_clk = ~core_clk;

    dmx_move_exec i_dmx_move_exec (
        .core_clk, .rst_n, .clk_en, .insn_valid, .insn_ready, .insn, .ptr0, .ptr1,
        .rf_rd_en, .rf_rd_addr, .rf_rd_data, .rf_wr_en, .rf_wr_addr, .rf_wr_data,
        .work_ld, .work_ld_data, .working_register, .zero_flag, .zero_we, .done,
        .unsupported
    );

    // Register file: combinational read, write at end of the write cycle
    assign rf_rd_data = mem[rf_rd_addr];
    always @(posedge core_clk) begin
        if (rf_wr_en === 1'b1) mem[rf_wr_addr] <= rf_wr_data;
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            conclude();
        end
    end

    function automatic logic [7:0] pat(input logic [7:0] a);
        return a ^ 8'h5A;
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic ldw(input logic [7:0] v);
        @(posedge core_clk);
        #1 work_ld = 1'b1;
        work_ld_data = v;
        @(posedge core_clk);
        #1 work_ld = 1'b0;
    endtask

    // Runs one instruction, frozen by clk_en for hold cycles after accept
    task automatic exe(input logic [15:0] word);
        int n;
        n = 0;
        s_rd = 1'b0;
        @(posedge core_clk);
        #1 insn = word;
        insn_valid = 1'b1;
        @(posedge core_clk);
        #1 insn_valid = 1'b0;
        if (hold > 0) begin
            clk_en = 1'b0;
            repeat (hold) @(posedge core_clk);
            #1 chk({6'h00, insn_ready, done}, 8'h00);
            clk_en = 1'b1;
        end
        #1;
        while (n < 8 && done !== 1'b1) begin
            if (rf_rd_en === 1'b1) begin
                s_rd = 1'b1;
                s_raddr = rf_rd_addr;
            end
            @(posedge core_clk);
            #1;
            n++;
        end
        chk({7'h00, done}, 8'h01);
        chk(n[7:0], 8'h02);
        s_wen = rf_wr_en;
        s_zwe = zero_we;
        s_waddr = rf_wr_addr;
        s_wdata = rf_wr_data;
        s_uns = unsupported;
        @(posedge core_clk);
        #1;
    endtask

    task automatic t_pf_direct();
        exe({3'b010, 5'h1F, 8'hFF});
        chk(s_raddr, 8'h1F);
        chk({7'h00, s_wen}, 8'h01);
        chk(s_waddr, 8'hFF);
        chk(s_wdata, pat(8'h1F));
        chk({7'h00, s_zwe}, 8'h01);
        chk({7'h00, zero_flag}, 8'h00);
        chk({7'h00, s_uns}, 8'h00);
        $display("finished pf_direct");
    endtask

    task automatic t_pf_zero();
        exe({3'b010, 5'h05, 8'h30});
        chk(s_wdata, 8'h00);
        chk({7'h00, zero_flag}, 8'h01);
        $display("finished pf_zero");
    endtask

    task automatic t_pf_w();
        ldw(8'hC3);
        exe({3'b010, 5'h0A, 8'h31});
        chk({7'h00, s_rd}, 8'h00);
        chk(s_waddr, 8'h31);
        chk(s_wdata, 8'hC3);
        exe({3'b010, 5'h10, 8'h0A});
        chk({7'h00, s_wen}, 8'h00);
        chk(working_register, pat(8'h10));
        $display("finished pf_w");
    endtask

    task automatic t_pf_ind();
        ptr0 = 8'h40;
        ptr1 = 8'h90;
        exe({3'b010, 5'h00, 8'h08});
        chk(s_raddr, 8'h40);
        chk(s_waddr, 8'h90);
        chk(s_wdata, pat(8'h40));
        exe({3'b010, 5'h08, 8'h00});
        chk(s_raddr, 8'h90);
        chk(s_waddr, 8'h40);
        chk(s_wdata, pat(8'h40));
        $display("finished pf_ind");
    endtask

    task automatic t_wf();
        exe({8'h01, 8'h80});
        chk(s_raddr, 8'h80);
        chk(s_waddr, 8'h80);
        chk(s_wdata, pat(8'h10));
        chk({7'h00, s_zwe}, 8'h00);
        chk({7'h00, zero_flag}, 8'h01);
        exe({8'h01, 8'h0A});
        chk({7'h00, s_wen}, 8'h00);
        chk(working_register, pat(8'h10));
        $display("finished wf");
    endtask

    task automatic t_hold();
        hold = 3;
        exe({3'b010, 5'h06, 8'h32});
        hold = 0;
        chk(s_waddr, 8'h32);
        chk(s_wdata, pat(8'h06));
        chk({7'h00, zero_flag}, 8'h00);
        $display("finished hold");
    endtask

    task automatic t_unsup();
        exe(16'hF000);
        chk({7'h00, s_uns}, 8'h01);
        chk({6'h00, s_wen, s_zwe}, 8'h00);
        chk({7'h00, zero_flag}, 8'h00);
        $display("finished unsup");
    endtask

    initial begin
        for (int i = 0; i < 256; i++) mem[i] = pat(i[7:0]);
        mem[5] = 8'h00;
        repeat (6) @(posedge core_clk);
        #1 rst_n = 1'b1;
        t_pf_direct();
        t_pf_w();
        t_pf_ind();
        t_pf_zero();
        t_wf();
        t_hold();
        t_unsup();
        conclude();
    end
endmodule
